//--- fap_pkg.sv
`default_nettype none
// ==========================================================================
// shared constants for the firmware alternate pin select block
// ==========================================================================
package fap_pkg;

  // ========================================================================
  // register indexes (8-bit configuration index space)
  // ========================================================================
  localparam logic [7:0] FAP_IDX_MISC_CONFIG_SIX = 8'h70;
  localparam logic [7:0] FAP_IDX_POWER_MGMT_CONTROL_THREE = 8'hAD;
  localparam logic [7:0] FAP_IDX_FUNCTION_ENABLE_ONE = 8'hB0;
  localparam logic [7:0] FAP_IDX_FUNCTION_ENABLE_TWO = 8'hB1;
  localparam logic [7:0] FAP_IDX_MISC_CONFIG_THREE = 8'hBA;
  localparam logic [7:0] FAP_IDX_PIN_STATUS = 8'hC0;

  // ========================================================================
  // field positions
  // ========================================================================
  localparam int FAP_BIT_SRAM_MODE = 0;
  localparam int FAP_BIT_XT_KBD = 3;
  localparam int FAP_BIT_CLK14_AUTOFEED = 3;
  localparam int FAP_POS_PPORT_MODE = 0;
  localparam int FAP_POS_OSC_ENABLE = 4;
  localparam int FAP_POS_OSC_SOURCE = 0;

  // ========================================================================
  // field encodings
  // ========================================================================
  localparam logic [1:0] FAP_PPORT_UNIDIR = 2'h0;
  localparam logic [1:0] FAP_PPORT_BIDIR = 2'h1;
  localparam logic [1:0] FAP_PPORT_EPP = 2'h2;
  localparam logic [1:0] FAP_OSC_SRC_BAUD = 2'h0;
  localparam logic [1:0] FAP_OSC_SRC_14M = 2'h1;

  // ========================================================================
  // reset values
  // ========================================================================
  localparam logic [7:0] FAP_CFG_RST = 8'h00;
  localparam logic [3:0] FAP_COL_STROBE_IDLE = 4'hF;
  localparam logic FAP_PPORT_WE_IDLE = 1'b1;
  localparam logic FAP_AUTOFEED_IDLE = 1'b1;

  // ========================================================================
  // synchroniser lanes for inputs from other clock domains or pins
  // ========================================================================
  localparam int FAP_SYNC_WIDTH = 5;
  localparam int FAP_SYNC_BAUD = 0;
  localparam int FAP_SYNC_CLK14 = 1;
  localparam int FAP_SYNC_BUSCLK = 2;
  localparam int FAP_SYNC_KBD_DATA = 3;
  localparam int FAP_SYNC_KBD_CLOCK = 4;

endpackage
`default_nettype wire

//--- fap_sync3.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// three-stage input synchroniser with agreement filter
// ==========================================================================
module fap_sync3 #(
  parameter int WIDTH = 5
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // asynchronous inputs and their filtered copy
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] stable_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } fap_sync_state_t;

  fap_sync_state_t st;
  fap_sync_state_t next_st;

  // s1 feeds only s2; the filter looks at s2 and s3
  always_comb begin
    next_st = st;
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.q[i] = st.s3[i];
      end
    end
  end

  // synchronous reset to a known level
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign stable_out = st.q;

endmodule // fap_sync3
`default_nettype wire

//--- fap_pin_select.sv
`timescale 1ns/1ps
`default_nettype none
module fap_pin_select
  import fap_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // configuration register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // memory controller side, same clock
  input wire logic [3:0] mc_col_strobe,
  input wire logic [3:0] mc_sram_sel,
  // column strobe pins
  output logic col_strobe_bank0_low,
  output logic col_strobe_bank0_high,
  output logic col_strobe_bank1_low,
  output logic col_strobe_bank1_high,
  // parallel port side, same clock
  input wire logic pp_write_enable_in,
  input wire logic pp_data_decode_in,
  input wire logic pp_autofeed_in,
  output logic pport_write_enable,
  output logic pport_autofeed,
  // clock sources from other domains
  input wire logic baud_clk_src,
  input wire logic clk_14m_src,
  input wire logic bus_clk_src,
  // oscillator output pin
  output logic oscillator_clock_pin_out,
  output logic oscillator_clock_pin_oe,
  // keyboard unit side, same clock
  input wire logic kbd_ctrl_select_in,
  input wire logic kbd_data_drive_low,
  input wire logic kbd_clock_drive_low,
  output logic kbd_serial_data,
  output logic kbd_serial_clock,
  // pin shared by controller select and keyboard data
  input wire logic kbd_select_data_pin_in,
  output logic kbd_select_data_pin_out,
  output logic kbd_select_data_pin_oe,
  // pin shared by bus system clock and keyboard clock
  input wire logic busclk_kbdclk_pin_in,
  output logic busclk_kbdclk_pin_out,
  output logic busclk_kbdclk_pin_oe
);

  // ========================================================================
  // state
  // ========================================================================
  typedef struct packed {
    logic [7:0] misc_config_six;
    logic [7:0] power_mgmt_control_three;
    logic [7:0] function_enable_one;
    logic [7:0] function_enable_two;
    logic [7:0] misc_config_three;
    logic [7:0] rdata;
    logic [3:0] col_pins;
    logic pp_we_pin;
    logic afd_pin;
    logic osc_out;
    logic osc_oe;
    logic p75_out;
    logic p75_oe;
    logic p45_out;
    logic p45_oe;
    logic kbd_data_rx;
    logic kbd_clock_rx;
  } fap_state_t;

  fap_state_t st;
  fap_state_t next_st;
  logic [FAP_SYNC_WIDTH-1:0] sync_raw;
  logic [FAP_SYNC_WIDTH-1:0] sync_q;
  logic sram_mode;
  logic [1:0] pport_mode;
  logic pport_alt;
  logic osc_enable;
  logic [1:0] osc_source;
  logic osc_driving;
  logic xt_mode;
  logic clk14_afd;
  logic [7:0] status_word;

  // ========================================================================
  // input synchronisers
  // ========================================================================
  // clock sources and pin levels come from outside sys_clk; the output
  // copies carry up to a few cycles of jitter, acceptable for slow loads
  assign sync_raw[FAP_SYNC_BAUD] = baud_clk_src;
  assign sync_raw[FAP_SYNC_CLK14] = clk_14m_src;
  assign sync_raw[FAP_SYNC_BUSCLK] = bus_clk_src;
  assign sync_raw[FAP_SYNC_KBD_DATA] = kbd_select_data_pin_in;
  assign sync_raw[FAP_SYNC_KBD_CLOCK] = busclk_kbdclk_pin_in;

  fap_sync3 #(
    .WIDTH(FAP_SYNC_WIDTH)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in(sync_raw),
    .stable_out(sync_q)
  );

  // ========================================================================
  // decoded selections
  // ========================================================================
  // select bits live only in software-written registers
  assign sram_mode = st.misc_config_six[FAP_BIT_SRAM_MODE];
  assign pport_mode = st.function_enable_one[FAP_POS_PPORT_MODE +: 2];
  assign pport_alt = (pport_mode == FAP_PPORT_BIDIR) || (pport_mode == FAP_PPORT_EPP);
  assign osc_enable = st.function_enable_one[FAP_POS_OSC_ENABLE];
  assign osc_source = st.function_enable_two[FAP_POS_OSC_SOURCE +: 2];
  assign osc_driving = osc_enable &&
    ((osc_source == FAP_OSC_SRC_BAUD) || (osc_source == FAP_OSC_SRC_14M));
  assign xt_mode = st.power_mgmt_control_three[FAP_BIT_XT_KBD];
  assign clk14_afd = st.misc_config_three[FAP_BIT_CLK14_AUTOFEED];

  // read-only view of which alternates are live and the keyboard levels
  assign status_word = {1'b0, st.kbd_clock_rx, st.kbd_data_rx, clk14_afd,
    xt_mode, osc_driving, pport_alt, sram_mode};

  // ========================================================================
  // next-state logic
  // ========================================================================
  always_comb begin
    next_st = st;
    next_st.rdata = 8'h00;

    if (reg_wr) begin
      case (reg_addr)
        FAP_IDX_MISC_CONFIG_SIX: next_st.misc_config_six = reg_wdata;
        FAP_IDX_POWER_MGMT_CONTROL_THREE: next_st.power_mgmt_control_three = reg_wdata;
        FAP_IDX_FUNCTION_ENABLE_ONE: next_st.function_enable_one = reg_wdata;
        FAP_IDX_FUNCTION_ENABLE_TWO: next_st.function_enable_two = reg_wdata;
        FAP_IDX_MISC_CONFIG_THREE: next_st.misc_config_three = reg_wdata;
        default: next_st.rdata = 8'h00; // unmapped and read-only: ignored
      endcase
    end

    // read data valid in the following cycle only
    if (reg_rd) begin
      case (reg_addr)
        FAP_IDX_MISC_CONFIG_SIX: next_st.rdata = st.misc_config_six;
        FAP_IDX_POWER_MGMT_CONTROL_THREE: next_st.rdata = st.power_mgmt_control_three;
        FAP_IDX_FUNCTION_ENABLE_ONE: next_st.rdata = st.function_enable_one;
        FAP_IDX_FUNCTION_ENABLE_TWO: next_st.rdata = st.function_enable_two;
        FAP_IDX_MISC_CONFIG_THREE: next_st.rdata = st.misc_config_three;
        FAP_IDX_PIN_STATUS: next_st.rdata = status_word;
        default: next_st.rdata = 8'h00;
      endcase
    end

    for (int i = 0; i < 4; i++) begin
      // lane i maps to lane i
      next_st.col_pins[i] = sram_mode ? mc_sram_sel[i] : mc_col_strobe[i];
    end

    next_st.pp_we_pin = pport_alt ? pp_data_decode_in : pp_write_enable_in;

    next_st.afd_pin = clk14_afd ? sync_q[FAP_SYNC_CLK14] : pp_autofeed_in;

    next_st.osc_out = 1'b0;
    if (osc_enable && (osc_source == FAP_OSC_SRC_BAUD)) begin
      next_st.osc_out = sync_q[FAP_SYNC_BAUD];
    end else if (osc_enable && (osc_source == FAP_OSC_SRC_14M)) begin
      next_st.osc_out = sync_q[FAP_SYNC_CLK14];
    end
    next_st.osc_oe = osc_driving;

    if (xt_mode) begin
      next_st.p75_out = 1'b0;
      next_st.p75_oe = kbd_data_drive_low;
      next_st.p45_out = 1'b0;
      next_st.p45_oe = kbd_clock_drive_low;
      next_st.kbd_data_rx = sync_q[FAP_SYNC_KBD_DATA];
      next_st.kbd_clock_rx = sync_q[FAP_SYNC_KBD_CLOCK];
    end else begin
      next_st.p75_out = kbd_ctrl_select_in;
      next_st.p75_oe = 1'b1;
      // forwarded only, drives no timing here
      next_st.p45_out = sync_q[FAP_SYNC_BUSCLK];
      next_st.p45_oe = 1'b1;
      // idle-high line level towards the keyboard unit
      next_st.kbd_data_rx = 1'b1;
      next_st.kbd_clock_rx = 1'b1;
    end

    if (rst) begin
      next_st = '0;
      next_st.misc_config_six = FAP_CFG_RST;
      next_st.power_mgmt_control_three = FAP_CFG_RST;
      next_st.function_enable_one = FAP_CFG_RST;
      next_st.function_enable_two = FAP_CFG_RST;
      next_st.misc_config_three = FAP_CFG_RST;
      next_st.col_pins = FAP_COL_STROBE_IDLE;
      next_st.pp_we_pin = FAP_PPORT_WE_IDLE;
      next_st.afd_pin = FAP_AUTOFEED_IDLE;
      next_st.p75_oe = 1'b1;
      next_st.p45_oe = 1'b1;
      next_st.kbd_data_rx = 1'b1;
      next_st.kbd_clock_rx = 1'b1;
    end
  end

  // single state register; reset is folded into next_st
  always_ff @(posedge sys_clk) begin
    st <= next_st;
  end

  // ========================================================================
  // outputs
  // ========================================================================
  assign reg_rdata = st.rdata;
  assign col_strobe_bank0_low = st.col_pins[0];
  assign col_strobe_bank0_high = st.col_pins[1];
  assign col_strobe_bank1_low = st.col_pins[2];
  assign col_strobe_bank1_high = st.col_pins[3];
  assign pport_write_enable = st.pp_we_pin;
  assign pport_autofeed = st.afd_pin;
  assign oscillator_clock_pin_out = st.osc_out;
  assign oscillator_clock_pin_oe = st.osc_oe;
  assign kbd_select_data_pin_out = st.p75_out;
  assign kbd_select_data_pin_oe = st.p75_oe;
  assign busclk_kbdclk_pin_out = st.p45_out;
  assign busclk_kbdclk_pin_oe = st.p45_oe;
  assign kbd_serial_data = st.kbd_data_rx;
  assign kbd_serial_clock = st.kbd_clock_rx;

  // ========================================================================
  // checks
  // ========================================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_sram_select;
    sram_mode |=> (col_strobe_bank0_low == $past(mc_sram_sel[0])) &&
      (col_strobe_bank0_high == $past(mc_sram_sel[1])) &&
      (col_strobe_bank1_low == $past(mc_sram_sel[2])) &&
      (col_strobe_bank1_high == $past(mc_sram_sel[3]));
  endproperty
  a_sram_select: assert property (p_sram_select)
    else $error("sram select not mapped to strobe pins");

  property p_sram_enable;
    (reg_wr && reg_addr == FAP_IDX_MISC_CONFIG_SIX && reg_wdata[FAP_BIT_SRAM_MODE])
      ##1 !reg_wr |=> {col_strobe_bank1_high, col_strobe_bank1_low,
      col_strobe_bank0_high, col_strobe_bank0_low} == $past(mc_sram_sel);
  endproperty
  a_sram_enable: assert property (p_sram_enable)
    else $error("sram mode write did not switch strobe pins");

  property p_dram_default;
    !sram_mode |=> {col_strobe_bank1_high, col_strobe_bank1_low,
      col_strobe_bank0_high, col_strobe_bank0_low} == $past(mc_col_strobe);
  endproperty
  a_dram_default: assert property (p_dram_default)
    else $error("column strobes not on pins in default mode");

  property p_pport_decode;
    pport_alt |=> pport_write_enable == $past(pp_data_decode_in);
  endproperty
  a_pport_decode: assert property (p_pport_decode)
    else $error("data decode missing on write enable pin");

  property p_pport_unidir;
    (pport_mode == FAP_PPORT_UNIDIR) |=> pport_write_enable == $past(pp_write_enable_in);
  endproperty
  a_pport_unidir: assert property (p_pport_unidir)
    else $error("write enable lost in unidirectional mode");

  property p_osc_source;
    (osc_enable && osc_source == FAP_OSC_SRC_BAUD) |=>
      oscillator_clock_pin_oe && (oscillator_clock_pin_out == $past(sync_q[FAP_SYNC_BAUD]));
  endproperty
  a_osc_source: assert property (p_osc_source)
    else $error("baud clock not driven on oscillator pin");

  property p_osc_tristate;
    !osc_driving |=> !oscillator_clock_pin_oe && !oscillator_clock_pin_out;
  endproperty
  a_osc_tristate: assert property (p_osc_tristate)
    else $error("oscillator pin driven with no source selected");

  property p_xt_keyboard;
    xt_mode |=> !kbd_select_data_pin_out && !busclk_kbdclk_pin_out &&
      (kbd_select_data_pin_oe == $past(kbd_data_drive_low)) &&
      (busclk_kbdclk_pin_oe == $past(kbd_clock_drive_low)) &&
      (kbd_serial_data == $past(sync_q[FAP_SYNC_KBD_DATA]));
  endproperty
  a_xt_keyboard: assert property (p_xt_keyboard)
    else $error("keyboard pins not open-drain in xt mode");

  property p_bus_clock;
    !xt_mode |=> busclk_kbdclk_pin_oe &&
      (busclk_kbdclk_pin_out == $past(sync_q[FAP_SYNC_BUSCLK]));
  endproperty
  a_bus_clock: assert property (p_bus_clock)
    else $error("bus system clock not forwarded");

  property p_clk14_autofeed;
    clk14_afd |=> pport_autofeed == $past(sync_q[FAP_SYNC_CLK14]);
  endproperty
  a_clk14_autofeed: assert property (p_clk14_autofeed)
    else $error("14.336 MHz clock missing on autofeed pin");

  property p_write_only;
    !reg_wr |=> $stable({st.misc_config_six, st.power_mgmt_control_three,
      st.function_enable_one, st.function_enable_two, st.misc_config_three});
  endproperty
  a_write_only: assert property (p_write_only)
    else $error("select bits changed without a write");

  property p_reset_clear;
    $fell(rst) |-> (status_word[4:0] == 5'h00) && (st.misc_config_six == FAP_CFG_RST);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("selections not cleared by reset");

endmodule // fap_pin_select
`default_nettype wire

//--- fap_loads_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// far side loads: keyboard lines with pull-ups on the two shared pins
// ==========================================================================
module fap_loads_model (
  // shared pin drivers from the block
  input wire logic data_pin_out,
  input wire logic data_pin_oe,
  input wire logic clock_pin_out,
  input wire logic clock_pin_oe,
  // keyboard pulling its lines low
  input wire logic kbd_pull_data,
  input wire logic kbd_pull_clock,
  // resolved wire levels
  output logic data_wire,
  output logic clock_wire
);
  // pull-up wins unless someone drives or pulls low; a driven 1 loses to a pull
  always_comb begin
    data_wire = 1'b1;
    clock_wire = 1'b1;
    if (data_pin_oe) begin
      data_wire = data_pin_out;
    end
    if (clock_pin_oe) begin
      clock_wire = clock_pin_out;
    end
    if (kbd_pull_data) begin
      data_wire = 1'b0;
    end
    if (kbd_pull_clock) begin
      clock_wire = 1'b0;
    end
  end
endmodule // fap_loads_model
`default_nettype wire

//--- firmware_alt_pin_select_tb.sv
`timescale 1ns/1ps
`default_nettype none
module firmware_alt_pin_select_tb;
  import fap_pkg::*;
  // ========================================================================
  // stimulus and observed signals
  // ========================================================================
  logic sys_clk, rst, reg_wr, reg_rd, pp_we, pp_dec, pp_afd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, got, exp_v;
  logic [3:0] mc_col_strobe, mc_sram_sel, col;
  logic [2:0] src;
  logic kbd_sel_in, kbd_dlow, kbd_clow, pull_d, pull_c;
  logic we_o, afd_o, osc_out, osc_oe, ser_d, ser_c, kd_out, kd_oe, kc_out, kc_oe, kd_in, kc_in;
  logic [7:0] idx [5];
  int n_fail, compares, cycles;
  integer seed;

  fap_pin_select fap_pin_select_inst (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mc_col_strobe(mc_col_strobe), .mc_sram_sel(mc_sram_sel),
    .col_strobe_bank0_low(col[0]), .col_strobe_bank0_high(col[1]),
    .col_strobe_bank1_low(col[2]), .col_strobe_bank1_high(col[3]),
    .pp_write_enable_in(pp_we), .pp_data_decode_in(pp_dec), .pp_autofeed_in(pp_afd),
    .pport_write_enable(we_o), .pport_autofeed(afd_o),
    .baud_clk_src(src[0]), .clk_14m_src(src[1]), .bus_clk_src(src[2]),
    .oscillator_clock_pin_out(osc_out), .oscillator_clock_pin_oe(osc_oe),
    .kbd_ctrl_select_in(kbd_sel_in), .kbd_data_drive_low(kbd_dlow),
    .kbd_clock_drive_low(kbd_clow), .kbd_serial_data(ser_d), .kbd_serial_clock(ser_c),
    .kbd_select_data_pin_in(kd_in), .kbd_select_data_pin_out(kd_out),
    .kbd_select_data_pin_oe(kd_oe), .busclk_kbdclk_pin_in(kc_in),
    .busclk_kbdclk_pin_out(kc_out), .busclk_kbdclk_pin_oe(kc_oe)
  );

  fap_loads_model fap_loads_model_inst (
    .data_pin_out(kd_out), .data_pin_oe(kd_oe), .clock_pin_out(kc_out),
    .clock_pin_oe(kc_oe), .kbd_pull_data(pull_d), .kbd_pull_clock(pull_c),
    .data_wire(kd_in), .clock_wire(kc_in)
  );

  // ========================================================================
  // clock and hang guard
  // ========================================================================
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // whole run is a few hundred cycles, so this ceiling only trips on a hang
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      $display("ERROR timeout expected %0d seen %0d", 0, cycles);
      end_sim();
    end
  end

  // ========================================================================
  // bus cycles, checks and expectations
  // ========================================================================
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe is taken
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    got = reg_rdata;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic exp_we(input logic [1:0] md, input logic we, input logic dec);
    return (md == FAP_PPORT_BIDIR || md == FAP_PPORT_EPP) ? dec : we;
  endfunction

  function automatic logic exp_osc_oe(input logic en, input logic [1:0] s);
    return en && (s == FAP_OSC_SRC_BAUD || s == FAP_OSC_SRC_14M);
  endfunction

  // every configuration register clear and every pin but the bus clock pin on its default function
  task automatic test_defaults(input string name);
    foreach (idx[i]) begin
      rd(idx[i]);
      chk("reg after reset", FAP_CFG_RST, got);
    end
    @(posedge sys_clk);
    mc_col_strobe <= 4'($random(seed));
    pp_we <= 1'($random(seed));
    kbd_sel_in <= 1'($random(seed));
    settle(3);
    chk("col pins default", {4'h0, mc_col_strobe}, {4'h0, col});
    chk("write enable default", {7'h0, pp_we}, {7'h0, we_o});
    chk("autofeed default", {7'h0, pp_afd}, {7'h0, afd_o});
    chk("osc pin undriven", 8'h00, {7'h0, osc_oe});
    chk("select pin default", {6'h0, kbd_sel_in, 1'b1}, {6'h0, kd_out, kd_oe});
    chk("kbd lines idle", 8'h03, {6'h0, ser_d, ser_c});
    $display("test %s done", name);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ========================================================================
  // main sequence
  // ========================================================================
  initial begin
    idx = '{FAP_IDX_MISC_CONFIG_SIX, FAP_IDX_POWER_MGMT_CONTROL_THREE,
      FAP_IDX_FUNCTION_ENABLE_ONE, FAP_IDX_FUNCTION_ENABLE_TWO, FAP_IDX_MISC_CONFIG_THREE};
    seed = 32'hd7cbde69;
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 18'h0};
    {mc_col_strobe, mc_sram_sel, src} = 11'h0;
    {pp_we, pp_dec, pp_afd, kbd_sel_in} = 4'hF;
    {kbd_dlow, kbd_clow, pull_d, pull_c} = 4'h0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    test_defaults("reset");
    // read back random values, then an unmapped index
    foreach (idx[i]) begin
      exp_v = 8'($random(seed));
      wr(idx[i], exp_v);
      rd(idx[i]);
      chk("reg readback", exp_v, got);
      wr(idx[i], 8'h00);
    end
    wr(8'h55, 8'hA5);
    rd(8'h55);
    chk("unmapped read", 8'h00, got);
    // status word is read-only: a write leaves only the idle keyboard levels
    wr(FAP_IDX_PIN_STATUS, 8'hFF);
    rd(FAP_IDX_PIN_STATUS);
    chk("status idle", 8'h60, got);
    $display("test registers done");
    // column strobes against SRAM selects, lane by lane
    for (int m = 0; m < 2; m++) begin
      wr(FAP_IDX_MISC_CONFIG_SIX, 8'(m));
      repeat (6) begin
        @(posedge sys_clk);
        mc_col_strobe <= 4'($random(seed));
        mc_sram_sel <= 4'($random(seed));
        settle(3);
        chk("col pins", {4'h0, m ? mc_sram_sel : mc_col_strobe}, {4'h0, col});
      end
    end
    wr(FAP_IDX_MISC_CONFIG_SIX, 8'h00);
    $display("test sram done");
    // every parallel mode, including the reserved code
    for (int md = 0; md < 4; md++) begin
      wr(FAP_IDX_FUNCTION_ENABLE_ONE, 8'(md));
      repeat (4) begin
        @(posedge sys_clk);
        pp_we <= 1'($random(seed));
        pp_dec <= 1'($random(seed));
        settle(3);
        chk("write enable pin", {7'h0, exp_we(2'(md), pp_we, pp_dec)}, {7'h0, we_o});
      end
    end
    $display("test pport done");
    // oscillator pin: enable against every source code
    for (int en = 0; en < 2; en++) begin
      for (int s = 0; s < 4; s++) begin
        wr(FAP_IDX_FUNCTION_ENABLE_ONE, 8'(en << FAP_POS_OSC_ENABLE));
        wr(FAP_IDX_FUNCTION_ENABLE_TWO, 8'(s));
        settle(3);
        chk("osc oe", {7'h0, exp_osc_oe(1'(en), 2'(s))}, {7'h0, osc_oe});
        for (int v = 1; v >= 0 && exp_osc_oe(1'(en), 2'(s)); v--) begin
          @(posedge sys_clk);
          src[s] <= 1'(v);
          src[1 - s] <= 1'(~v);
          settle(8);
          chk("osc out", 8'(v), {7'h0, osc_out});
        end
      end
    end
    wr(FAP_IDX_FUNCTION_ENABLE_ONE, 8'h00);
    $display("test osc done");
    // autofeed carries the 14 MHz source, then its own signal again
    wr(FAP_IDX_MISC_CONFIG_THREE, 8'(1 << FAP_BIT_CLK14_AUTOFEED));
    for (int v = 1; v >= 0; v--) begin
      @(posedge sys_clk);
      src[1] <= 1'(v);
      pp_afd <= 1'(~v);
      settle(8);
      chk("autofeed clock", 8'(v), {7'h0, afd_o});
    end
    wr(FAP_IDX_MISC_CONFIG_THREE, 8'h00);
    settle(3);
    chk("autofeed back", {7'h0, pp_afd}, {7'h0, afd_o});
    // bus clock forwarded as a plain output outside keyboard mode
    for (int v = 1; v >= 0; v--) begin
      @(posedge sys_clk);
      src[2] <= 1'(v);
      settle(8);
      chk("bus_sys_clock_out pin", {6'h0, 1'(v), 1'b1}, {6'h0, kc_out, kc_oe});
    end
    $display("test clocks done");
    // keyboard mode: every combination of own and far pull-downs
    wr(FAP_IDX_POWER_MGMT_CONTROL_THREE, 8'(1 << FAP_BIT_XT_KBD));
    for (int i = 0; i < 16; i++) begin
      @(posedge sys_clk);
      {kbd_dlow, pull_d, kbd_clow, pull_c} <= 4'(i);
      settle(8);
      chk("kbd lines", {4'h0, kbd_dlow, kbd_clow, ~(kbd_dlow | pull_d), ~(kbd_clow | pull_c)},
        {4'h0, kd_oe, kc_oe, ser_d, ser_c});
    end
    @(posedge sys_clk);
    {kbd_dlow, pull_d, kbd_clow, pull_c} <= 4'h0;
    $display("test keyboard done");
    // second reset with every select set: nothing survives it
    wr(FAP_IDX_MISC_CONFIG_SIX, 8'h01);
    wr(FAP_IDX_FUNCTION_ENABLE_ONE, 8'h11);
    wr(FAP_IDX_MISC_CONFIG_THREE, 8'h08);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    test_defaults("second reset");
    end_sim();
  end
endmodule // firmware_alt_pin_select_tb
`default_nettype wire
